// [shaft_encoder_decoder.sv]
// Shaft encoder decoder with an AHB-Lite register slave.
module shaft_encoder_decoder #(
  parameter int unsigned BASE_DIV = shaft_pkg::BASE_CYC,
  parameter int unsigned STEP_DIV = shaft_pkg::STEP_CYC,
  parameter int unsigned FAST_DIV = shaft_pkg::FAST_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [shaft_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [shaft_pkg::DATA_W-1:0] hrdata,
  input wire logic [shaft_pkg::DI_N-1:0] di_in,
  output logic odd_input_state,
  output logic even_input_state
);
  import shaft_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic ph_q;
  logic ph_wr_q;
  logic [ADDR_W-1:0] ph_addr_q;
  logic [DATA_W-1:0] hrdata_q;
  logic en_q;
  style_t style_q;
  logic [PAIR_W-1:0] pair_q;
  logic [IVL_W-1:0] ivl_q;
  logic signed [VAL_W-1:0] preset_q;
  logic signed [SCALE_W-1:0] scale_q;
  logic signed [CNT_W-1:0] count_q;
  logic signed [VAL_W-1:0] value_q;
  logic signed [VAL_W-1:0] mid_q;
  logic [DIV_W-1:0] base_cnt_q;
  logic [DIV_W-1:0] step_cnt_q;
  logic [FAST_W-1:0] fast_cnt_q;
  logic [IVL_W-1:0] ivl_cnt_q;
  logic [DI_N-1:0] di_m_q;
  logic [DI_N-1:0] di_s_q;
  logic pa_q;
  logic pb_q;
  logic odd_q;
  logic even_q;

  ////////////////////////////////////////////////////////////////////
  // The slave never stretches a transfer and every answer is OKAY; hsize
  // is not decoded because only whole-word access is supported.
  wire addr_ok = hsel & hready & htrans[1];
  wire [ADDR_W-1:0] a_addr = haddr[ADDR_W-1:0];
  wire wr_en = ph_q & ph_wr_q;
  wire wr_ctrl = wr_en & (ph_addr_q == CTRL_OFF);
  wire wr_ivl = wr_en & (ph_addr_q == IVL_OFF);
  wire wr_preset = wr_en & (ph_addr_q == PRESET_OFF);
  wire wr_scale = wr_en & (ph_addr_q == SCALE_OFF);
  wire preset_w = wr_en & (ph_addr_q == CMD_OFF) & hwdata[CMD_PRESET_BIT];
  wire [DATA_W-1:0] ctrl_rd = DATA_W'({pair_q, style_q, en_q});
  wire [DATA_W-1:0] stat_rd = DATA_W'({en_q, even_q, odd_q});
  wire [DATA_W-1:0] rd_mux =
    (a_addr == CTRL_OFF) ? ctrl_rd :
    (a_addr == IVL_OFF) ? DATA_W'(ivl_q) :
    (a_addr == PRESET_OFF) ? preset_q :
    (a_addr == SCALE_OFF) ? DATA_W'(signed'(scale_q)) :
    (a_addr == STATUS_OFF) ? stat_rd :
    (a_addr == COUNT_OFF) ? DATA_W'(signed'(count_q)) :
    (a_addr == VALUE_OFF) ? value_q :
    (a_addr == MID_OFF) ? mid_q : '0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= '0;
      hrdata_q <= '0;
    end else begin
      ph_q <= addr_ok;
      ph_wr_q <= hwrite;
      ph_addr_q <= a_addr;
      if (addr_ok && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
      style_q <= STY_QUAD;
      pair_q <= '0;
      ivl_q <= '0;
      preset_q <= '0;
      scale_q <= SCALE_RST;
    end else begin
      if (wr_ctrl) begin
        en_q <= hwdata[CTRL_EN_BIT];
        style_q <= style_t'(hwdata[CTRL_STYLE_LSB +: 3]);
        pair_q <= hwdata[CTRL_PAIR_LSB +: PAIR_W];
      end
      if (wr_ivl) begin
        ivl_q <= hwdata[IVL_W-1:0];
      end
      if (wr_preset) begin
        preset_q <= hwdata;
      end
      if (wr_scale) begin
        scale_q <= hwdata[SCALE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample pacing: 256 Hz base tick, 4 ms interval steps, fast tick for short pulses
  wire base_tick = base_cnt_q == DIV_W'(BASE_DIV - 1);
  wire step_tick = step_cnt_q == DIV_W'(STEP_DIV - 1);
  wire fast_tick = fast_cnt_q == FAST_W'(FAST_DIV - 1);
  wire ivl_hit = step_tick & (ivl_cnt_q == ivl_q - 8'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_cnt_q <= '0;
      step_cnt_q <= '0;
      fast_cnt_q <= '0;
      ivl_cnt_q <= '0;
    end else begin
      base_cnt_q <= base_tick ? '0 : base_cnt_q + 1'b1;
      step_cnt_q <= step_tick ? '0 : step_cnt_q + 1'b1;
      fast_cnt_q <= fast_tick ? '0 : fast_cnt_q + 1'b1;
      // A new interval restarts the interval count but not step_cnt_q, so the first sample can come up to one step short of an interval away.
      if (wr_ivl) begin
        ivl_cnt_q <= '0;
      end else if (step_tick) begin
        ivl_cnt_q <= ivl_hit ? '0 : ivl_cnt_q + 1'b1;
      end
    end
  end

  wire is_quad = style_q == STY_QUAD;
  wire is_cdir = style_q == STY_CDIR;
  wire is_short = style_q == STY_SHORT;
  wire is_pair = is_short | (style_q == STY_UPDN);
  wire samp = en_q & (is_short ? fast_tick : (ivl_q == '0) ? base_tick : ivl_hit);

  ////////////////////////////////////////////////////////////////////
  // odd/even pair select
  wire a_s = di_s_q[{pair_q, 1'b0}];
  wire b_s = di_s_q[{pair_q, 1'b1}];
  wire a_chg = a_s ^ pa_q;
  wire b_chg = b_s ^ pb_q;
  wire a_rise = a_s & ~pa_q;
  wire b_rise = b_s & ~pb_q;
  wire q_move = a_chg ^ b_chg;
  wire q_up = a_s ^ pb_q;
  wire inc_w = is_quad ? (q_move & q_up) :
               is_cdir ? (a_rise & b_s) :
               is_pair ? (a_rise & ~b_rise) : 1'b0;
  wire dec_w = is_quad ? (q_move & ~q_up) :
               is_cdir ? (a_rise & ~b_s) :
               is_pair ? (b_rise & ~a_rise) : 1'b0;
  wire signed [CNT_W+SCALE_W-1:0] prod_w = count_q * scale_q;
  wire signed [VAL_W-1:0] prod_v = VAL_W'(prod_w);

  // Pins are asynchronous, so two stages guard against metastability.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      di_m_q <= '0;
      di_s_q <= '0;
      odd_q <= 1'b0;
      even_q <= 1'b0;
    end else begin
      di_m_q <= di_in;
      di_s_q <= di_m_q;
      odd_q <= a_s;
      even_q <= b_s;
    end
  end

  assign odd_input_state = odd_q;
  assign even_input_state = even_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      count_q <= '0;
    end else if (samp) begin
      pa_q <= a_s;
      pb_q <= b_s;
      if (inc_w && count_q != CNT_MAX) begin
        count_q <= count_q + 17'sh0_0001;
      end else if (dec_w && count_q != CNT_MIN) begin
        count_q <= count_q - 17'sh0_0001;
      end
    end
  end

  // The midpoint reference makes later counts independent of the preset count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mid_q <= '0;
      value_q <= '0;
    end else if (preset_w) begin
      mid_q <= preset_q - prod_v;
      value_q <= preset_q;
    end else if (en_q) begin
      value_q <= mid_q + prod_v;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // The pacing checks time real samples, so a broken gate on samp shows up.
  wire base_mode = en_q & ~is_short & (ivl_q == '0);
  wire ivl_mode = en_q & ~is_short & (ivl_q != '0);
  logic [DIV_W-1:0] gap_q;
  logic seen_q;
  logic [IVL_W:0] steps_q;
  logic ivl_seen_q;
  // Seen flags drop whenever the pacing mode changes, so a mode switch is never judged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= '0;
      seen_q <= 1'b0;
      steps_q <= '0;
      ivl_seen_q <= 1'b0;
    end else begin
      gap_q <= samp ? '0 : gap_q + 1'b1;
      seen_q <= base_mode & (seen_q | samp);
      steps_q <= samp ? '0 : steps_q + {{IVL_W{1'b0}}, step_tick};
      ivl_seen_q <= ivl_mode & ~wr_ivl & (ivl_seen_q | samp);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  base_pace_a: assert property (
    samp && seen_q && base_mode |-> gap_q == DIV_W'(BASE_DIV - 1))
    else $error("Sample tick spacing wrong.");
  ivl_pace_a: assert property (
    samp && ivl_seen_q && ivl_mode |-> {1'b0, ivl_q} == steps_q + 1'b1)
    else $error("Sample interval wrong.");
  // Every counting style is checked in both directions.
  quad_down_a: assert property (
    samp && is_quad && a_chg && !b_chg && !q_up && count_q != CNT_MIN
    |=> count_q == $past(count_q) - 17'sh0_0001)
    else $error("Quadrature step not counted down.");
  cdir_up_a: assert property (
    samp && is_cdir && a_rise && b_s && count_q != CNT_MAX
    |=> count_q == $past(count_q) + 17'sh0_0001)
    else $error("Direction high did not count up.");
  updn_up_a: assert property (
    samp && is_pair && a_rise && !b_rise && count_q != CNT_MAX
    |=> count_q == $past(count_q) + 17'sh0_0001)
    else $error("Up input did not increment.");
  short_up_a: assert property (
    samp && is_short && a_rise && !b_rise && count_q != CNT_MAX
    |=> count_q == $past(count_q) + 17'sh0_0001)
    else $error("Short up pulse not counted.");
  pair_low_a: assert property (
    pair_q == 2'h0 ##1 pair_q == 2'h0
    |-> odd_q == $past(di_s_q[0]) && even_q == $past(di_s_q[1]))
    else $error("Level echo wrong.");
  hold_off_a: assert property (
    !en_q && !preset_w |=> $stable(count_q) && $stable(value_q))
    else $error("Disabled decoder changed state.");
  quad_up_a: assert property (
    samp && is_quad && a_chg && !b_chg && q_up && count_q != CNT_MAX
    |=> count_q == $past(count_q) + 17'sh0_0001)
    else $error("Quadrature step not counted up.");
  cdir_down_a: assert property (
    samp && is_cdir && a_rise && !b_s && count_q != CNT_MIN
    |=> count_q == $past(count_q) - 17'sh0_0001)
    else $error("Direction low did not count down.");
  updn_down_a: assert property (
    samp && is_pair && b_rise && !a_rise && count_q != CNT_MIN
    |=> count_q == $past(count_q) - 17'sh0_0001)
    else $error("Down input did not decrement.");
  short_pace_a: assert property (
    en_q && is_short |-> samp == fast_tick)
    else $error("Short pulse style not fast sampled.");
  pair_top_a: assert property (
    pair_q == 2'h3 ##1 pair_q == 2'h3 |-> odd_q == $past(di_s_q[6]) && even_q == $past(di_s_q[7]))
    else $error("Pair select wrong.");
  preset_load_a: assert property (
    preset_w |=> value_q == $past(preset_q))
    else $error("Preset not loaded.");
  preset_hold_a: assert property (
    (preset_w && !samp) ##1 (en_q && !preset_w) |=> value_q == $past(preset_q, 2))
    else $error("Converted value drifted after preset.");
  cnt_range_a: assert property (
    count_q <= CNT_MAX && count_q >= CNT_MIN)
    else $error("Counter out of range.");
  mid_ref_a: assert property (
    preset_w |=> mid_q == $past(preset_q) - $past(prod_v))
    else $error("Midpoint reference wrong.");
  quad_bad_a: assert property (
    samp && is_quad && a_chg && b_chg |=> $stable(count_q))
    else $error("Double phase change counted.");
  level_once_a: assert property (
    samp && is_cdir && a_s && pa_q |=> $stable(count_q))
    else $error("High level counted again.");

  quad_cnt_c: cover property (samp && is_quad && inc_w);
  cdir_cnt_c: cover property (samp && is_cdir && dec_w);
  short_cnt_c: cover property (samp && is_short && inc_w);
  preset_c: cover property (preset_w ##1 en_q [*3]);
  ivl_cnt_c: cover property (samp && ivl_mode && is_pair && inc_w);
endmodule // shaft_encoder_decoder

// [shaft_pkg.sv]
// Constants, register map and types for the shaft encoder decoder.
package shaft_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SAMPLE_HZ = 256;
  localparam int unsigned STEP_MS = 4;
  localparam int unsigned MIN_PULSE_US = 300;
  localparam int unsigned BASE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  // Four samples per shortest pulse so a 300 us pulse is never missed.
  localparam int unsigned FAST_CYC = CLK_HZ / 1_000_000 * MIN_PULSE_US / 4;
  localparam int DIV_W = 18;
  localparam int FAST_W = 12;
  localparam int DI_N = 8;
  localparam int PAIR_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IVL_W = 8;
  localparam int CNT_W = 17;
  localparam int SCALE_W = 16;
  localparam int VAL_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] IVL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] PRESET_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] SCALE_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] COUNT_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] VALUE_OFF = 8'h1C;
  localparam logic [ADDR_W-1:0] MID_OFF = 8'h20;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STYLE_LSB = 1;
  localparam int CTRL_PAIR_LSB = 4;
  localparam int CMD_PRESET_BIT = 0;
  localparam int ST_ODD_BIT = 0;
  localparam int ST_EVEN_BIT = 1;
  localparam int ST_EN_BIT = 2;
  localparam logic [SCALE_W-1:0] SCALE_RST = 16'h0001;
  localparam logic signed [CNT_W-1:0] CNT_MAX = 17'sh0_8000;
  localparam logic signed [CNT_W-1:0] CNT_MIN = 17'sh1_8000;
  localparam logic [1:0] TRANS_NONSEQ_BIT = 2'h2;
  typedef enum logic [2:0] {
    STY_NONE = 3'h0,
    STY_QUAD = 3'h1,
    STY_CDIR = 3'h2,
    STY_UPDN = 3'h3,
    STY_SHORT = 3'h4
  } style_t;
endpackage

// [shaft_encoder_model.sv]
// Behavioural shaft encoder that drives the eight digital input lines.
module shaft_encoder_model #(
  parameter int MIN_HOLD = 1
) (
  input wire logic hclk,
  output logic [7:0] di_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial di_in = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // Minimum pulse width.
  // A real encoder cannot produce a level shorter than its floor, so neither does this one.
  task automatic put(input logic [7:0] v, input int n);
    @(posedge hclk);
    di_in <= v;
    repeat ((n < MIN_HOLD ? MIN_HOLD : n) - 1) @(posedge hclk);
  endtask
endmodule // shaft_encoder_model

// [testbench.sv]
// Self-checking testbench for the shaft encoder decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import shaft_pkg::*;
  localparam int H = 120;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, odd_s, even_s;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd, mid, scale, pv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] di_in, lv;
  int errors, compares, cnt, en, qp;
  ////////////////////////////////////////////////////////////////////////////////
  shaft_encoder_decoder #(.BASE_DIV(50), .STEP_DIV(40), .FAST_DIV(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .di_in(di_in),
    .odd_input_state(odd_s), .even_input_state(even_s));
  // Style 4 ticks every 8 cycles, so 32 cycles stands in for the 300 us floor.
  shaft_encoder_model #(.MIN_HOLD(32)) enc_u (.hclk(hclk), .di_in(di_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic ctrl(input int e, input int s, input int p);
    bus(1'b1, CTRL_OFF, 32'(p * 16 + s * 2 + e));
    en = e;
  endtask
  // The bench model adds the expected step only while counting is enabled.
  task automatic pulse(input int b, input int d, input int h);
    enc_u.put(lv | 8'(1 << b), h);
    enc_u.put(lv, h);
    cnt += en * d;
  endtask
  task automatic quad(input int s, input int d);
    qp = (qp + s) % 4;
    enc_u.put({6'h0, qp[1], qp[1] ^ qp[0]}, H);
    cnt += en * d;
  endtask
  task automatic chk();
    rdc(COUNT_OFF, 32'(cnt));
    rdc(VALUE_OFF, mid + 32'(cnt) * scale);
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    print_verdict();
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    hsize = 3'h2;
    lv = 8'h00;
    rnd = 32'h0001_6EEE;
    {errors, compares, cnt, en, qp} = '0;
    mid = 32'h0000_0000;
    scale = 32'h0000_0001;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(CTRL_OFF, 32'h0000_0002);
    rdc(SCALE_OFF, 32'h0000_0001);
    rdc(COUNT_OFF, 32'h0000_0000);
    rdc(8'h24, 32'h0000_0000);
    for (int p = 0; p < 4; p++) begin
      for (int c = 1; c < 3; c++) begin
        ctrl(0, 1, p);
        enc_u.put(8'hFF & ~8'((3 ^ c) << (2 * p)), 6);
        cmp({30'h0, even_s, odd_s}, 32'(c));
        rdc(STATUS_OFF, 32'(c));
        enc_u.put(8'h00, 6);
      end
    end
    ctrl(0, 3, 0);
    pulse(0, 1, H);
    rdc(COUNT_OFF, 32'(cnt));
    ctrl(1, 3, 1);
    pulse(2, 1, H);
    pulse(2, 1, H);
    pulse(3, -1, H);
    chk();
    ctrl(1, 2, 2);
    lv = 8'h20;
    enc_u.put(lv, H);
    pulse(4, 1, H);
    lv = 8'h00;
    enc_u.put(lv, H);
    pulse(4, -1, H);
    pulse(4, -1, H);
    chk();
    ctrl(1, 4, 3);
    pulse(6, 1, 32);
    pulse(7, -1, 32);
    pulse(7, -1, 32);
    chk();
    ctrl(1, 0, 0);
    pulse(0, 0, H);
    chk();
    ctrl(1, 1, 0);
    repeat (5) quad(1, 1);
    repeat (2) quad(3, -1);
    quad(2, 0);
    quad(3, -1);
    chk();
    bus(1'b1, IVL_OFF, 32'h0000_0002);
    ctrl(1, 3, 0);
    pulse(0, 1, H);
    chk();
    bus(1'b1, IVL_OFF, 32'h0000_0000);
    // Preset while disabled must still load the output at once.
    rnd = lfsr(lfsr(rnd));
    scale = {{16{rnd[15]}}, rnd[15:0]};
    rnd = lfsr(rnd);
    pv = rnd;
    ctrl(0, 3, 0);
    bus(1'b1, SCALE_OFF, scale);
    bus(1'b1, PRESET_OFF, pv);
    bus(1'b1, CMD_OFF, 32'h0000_0001);
    mid = pv - 32'(cnt) * scale;
    rdc(VALUE_OFF, pv);
    rdc(MID_OFF, mid);
    rdc(SCALE_OFF, scale);
    ctrl(1, 3, 0);
    repeat (int'(rnd[1:0]) + 1) pulse(0, 1, H);
    pulse(1, -1, H);
    chk();
    // A preset while counting must also take effect at once.
    rnd = lfsr(rnd);
    pv = rnd;
    bus(1'b1, PRESET_OFF, pv);
    bus(1'b1, CMD_OFF, 32'h0000_0001);
    mid = pv - 32'(cnt) * scale;
    rdc(VALUE_OFF, pv);
    rdc(MID_OFF, mid);
    print_verdict();
  end
endmodule // testbench
